// ==== design/pmc_ctrl.sv ====
/*
  power mode and clock gate controller with its two control registers.
  assumes an i2c slave engine on clk that decodes register accesses and
  flags own address matches; pins arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none

module pmc_ctrl
  import pmc_pkg::*;
#(
  parameter int unsigned TICK_DIV = SLOW_DIV
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire pmc_reg_req_t reg_req,
  output logic [7:0]        rd_data,
  input  wire logic         addr_match,
  input  wire logic         rw_bit,
  input  wire logic         txn_done,
  input  wire logic         scl_i,
  output logic              scl_o,
  output logic              scl_oe_n,
  input  wire logic         rc_ready,
  input  wire logic         wake_pin,
  input  wire logic         key_detect,
  input  wire logic         hotkey_evt,
  input  wire logic         key_scan_irq,
  input  wire logic         rotary_irq,
  output pmc_gate_t         gate,
  output logic              rc_osc_on,
  output logic              osc_off,
  output logic              ext_clk_sel,
  output logic              soft_reset,
  output pmc_state_t        mode
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  pmc_state_t state_q;
  pmc_state_t state_d;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       scl_s;
  logic       rdy_s;
  logic       wake_s;
  logic       key_s;
  logic       wake_d1_q;
  logic [15:0] div_q;
  logic       tick_q;
  logic [3:0] en_q;
  logic       hib_q;
  logic       ext_q;
  logic       srst_q;
  logic [3:0] ctl2_q;
  logic       busy_q;
  logic [15:0] doze_q;
  logic       doze_fire;
  logic       stretch_q;
  logic       wr1;
  logic       wr2;
  logic       i2c_wake;
  logic       wake_evt;
  logic       deb_start;
  logic       deb_ok;
  logic       deb_bad;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {key_detect, wake_pin, rc_ready, scl_i};
      sync2_q <= sync1_q;
    end
  end

  assign scl_s  = sync2_q[0];
  assign rdy_s  = sync2_q[1];
  assign wake_s = sync2_q[2];
  assign key_s  = sync2_q[3];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_d1_q <= 1'b0;
    end else begin
      wake_d1_q <= wake_s;
    end
  end

  // ****************************************************************
  // 32 kHz tick divider
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == 16'(TICK_DIV - 1)) begin
      div_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  // writes only count while operational
  assign wr1 = reg_req.wr && reg_req.addr == ADDR_SYSCTL &&
               state_q == PMC_OPER && !srst_q;
  assign wr2 = reg_req.wr && reg_req.addr == ADDR_SYSCTL2 &&
               state_q == PMC_OPER && !srst_q;
  assign i2c_wake = addr_match && rw_bit == RW_WRITE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= SYSCTL_RST[3:0];
      ext_q <= SYSCTL_RST[BIT_EXTCLK];
    end else if (srst_q) begin
      en_q <= SYSCTL_RST[3:0];
      ext_q <= SYSCTL_RST[BIT_EXTCLK];
    end else if (wr1) begin
      en_q <= reg_req.wdata[3:0];
      ext_q <= reg_req.wdata[BIT_EXTCLK];
    end
  end

  // oscillator-off bit: host may only set it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hib_q <= SYSCTL_RST[BIT_OSCOFF];
    end else if (srst_q || (i2c_wake && state_q != PMC_OPER)) begin
      hib_q <= 1'b0;
    end else if (wr1 && reg_req.wdata[BIT_OSCOFF]) begin
      hib_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr1 && reg_req.wdata[BIT_SRST];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl2_q <= SYSCTL2_RST[3:0];
    end else if (srst_q) begin
      ctl2_q <= SYSCTL2_RST[3:0];
    end else if (wr2) begin
      ctl2_q <= reg_req.wdata[3:0];
    end
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (reg_req.rd && reg_req.addr == ADDR_SYSCTL) begin
      rd_data <= {srst_q, ext_q, hib_q,
                  state_q == PMC_SLEEP || state_q == PMC_KEYCHK, en_q};
    end else if (reg_req.rd && reg_req.addr == ADDR_SYSCTL2) begin
      rd_data <= {4'h0, ctl2_q};
    end else if (reg_req.rd) begin
      rd_data <= 8'h00;
    end
  end

  // ****************************************************************
  // auto-sleep countdown
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (addr_match) begin
      busy_q <= 1'b1;
    end else if (txn_done || srst_q) begin
      busy_q <= 1'b0;
    end
  end

  // own transactions and SYSCTL2 writes reload the count; it is held loaded outside PMC_OPER or with doze off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doze_q <= doze_ticks(SYSCTL2_RST[2:0]);
    end else if (state_q != PMC_OPER || !ctl2_q[BIT_DOZE_EN] ||
                 busy_q || addr_match || txn_done || wr2) begin
      doze_q <= doze_ticks(ctl2_q[2:0]);
    end else if (tick_q && doze_q != 16'h0000) begin
      doze_q <= doze_q - 16'h0001;
    end
  end

  assign doze_fire = state_q == PMC_OPER && ctl2_q[BIT_DOZE_EN] &&
                     !busy_q && tick_q && doze_q == 16'h0001;

  // ****************************************************************
  // hibernate key debounce
  // ****************************************************************
  assign deb_start = state_q == PMC_HIBER && key_s && !i2c_wake;

  pmc_debounce #(
    .TICKS (DEB_TICKS)
  ) u_deb (
    .clk     (clk),
    .rst     (rst),
    .start   (deb_start),
    .tick    (tick_q),
    .level   (key_s),
    .valid   (deb_ok),
    .invalid (deb_bad)
  );

  // ****************************************************************
  // mode state machine
  // ****************************************************************
  assign wake_evt = i2c_wake || (wake_s && !wake_d1_q) || hotkey_evt ||
                    key_scan_irq || rotary_irq;

  always_comb begin
    state_d = state_q;
    case (state_q)
      PMC_OPER: begin
        if (wr1 && reg_req.wdata[BIT_OSCOFF]) begin
          state_d = PMC_HIBER;
        end else if (wr1 && reg_req.wdata[BIT_SLEEP]) begin
          state_d = PMC_SLEEP;
        end else if (doze_fire) begin
          state_d = PMC_SLEEP;
        end
      end
      PMC_SLEEP: begin
        if (wake_evt) begin
          state_d = PMC_OPER;
        end
      end
      PMC_HIBER: begin
        // hotkeys are not looked at here
        if (i2c_wake) begin
          state_d = PMC_OPER;
        end else if (key_s) begin
          state_d = PMC_KEYCHK;
        end
      end
      PMC_KEYCHK: begin
        if (i2c_wake) begin
          state_d = PMC_OPER;
        end else if (deb_ok) begin
          state_d = PMC_SLEEP;
        end else if (deb_bad) begin
          state_d = PMC_HIBER;
        end
      end
      default: begin
        state_d = PMC_OPER;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PMC_OPER;
    end else if (srst_q) begin
      state_q <= PMC_OPER;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // clock gates and oscillator controls
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gate        <= '0;
      rc_osc_on   <= 1'b0;
      osc_off     <= 1'b0;
      ext_clk_sel <= 1'b0;
      soft_reset  <= 1'b0;
      mode        <= PMC_OPER;
    end else begin
      gate.rc_en   <= state_q == PMC_OPER ? en_q : 4'h0;
      gate.slow_en <= state_q == PMC_HIBER ? 4'h0 : en_q;
      rc_osc_on    <= state_q == PMC_OPER;
      osc_off      <= state_q == PMC_HIBER;
      ext_clk_sel  <= ext_q;
      soft_reset   <= srst_q;
      mode         <= state_q;
    end
  end

  // ****************************************************************
  // serial clock stretch on wake
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stretch_q <= 1'b0;
    end else if (i2c_wake && state_q != PMC_OPER) begin
      stretch_q <= 1'b1;
    end else if (rdy_s) begin
      stretch_q <= 1'b0;
    end
  end

  // grab the line only while the master already holds it low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_oe_n <= 1'b1;
      scl_o    <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      if (!stretch_q || rdy_s) begin
        scl_oe_n <= 1'b1;
      end else if (!scl_s) begin
        scl_oe_n <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_sleep_req;
    state_q == PMC_OPER && wr1 && reg_req.wdata[BIT_SLEEP] &&
    !reg_req.wdata[BIT_OSCOFF];
  endsequence

  sequence s_stretch_low;
    stretch_q && !scl_s && !rdy_s;
  endsequence

  AST_GATE_OFF: assert property (
    1'b1 |=> (gate.rc_en & ~$past(en_q)) == 4'h0
  ) else $error("disabled unit still clocked");

  AST_SLEEP_ENTER: assert property (
    s_sleep_req |=> state_q == PMC_SLEEP ##1 osc_off == 1'b0
  ) else $error("sleep request not taken");

  AST_HIB_HOLD: assert property (
    hib_q && !i2c_wake && !srst_q |=> hib_q
  ) else $error("hibernate bit cleared without wake");

  AST_EXT_SEL: assert property (
    wr1 |=> ##1 ext_clk_sel == $past(reg_req.wdata[BIT_EXTCLK], 2)
  ) else $error("clock source select wrong");

  AST_SRST: assert property (
    wr1 && reg_req.wdata[BIT_SRST] |=> srst_q ##1
    (!srst_q && en_q == SYSCTL_RST[3:0] && state_q == PMC_OPER)
  ) else $error("soft reset sequence wrong");

  AST_RSVD: assert property (
    reg_req.rd && reg_req.addr == ADDR_SYSCTL2 |=> rd_data[7:4] == 4'h0
  ) else $error("reserved bits not zero");

  AST_DOZE: assert property (
    doze_fire && !wr1 && !srst_q |=> state_q == PMC_SLEEP
  ) else $error("auto-sleep timeout ignored");

  AST_WAKE: assert property (
    state_q == PMC_SLEEP && wake_evt && !srst_q |=> state_q == PMC_OPER
  ) else $error("sleep wake missed");

  AST_STRETCH: assert property (
    s_stretch_low ##1 !rdy_s |=> !scl_oe_n
  ) else $error("serial clock not held on wake");

  AST_HIB_DARK: assert property (
    state_q == PMC_HIBER |=> gate == '0 && osc_off && !rc_osc_on
  ) else $error("clocks running in hibernate");

  AST_HOTKEY_HIB: assert property (
    state_q == PMC_HIBER && !i2c_wake && !key_s && !srst_q
    |=> state_q == PMC_HIBER
  ) else $error("hibernate left without wake or key");

endmodule // pmc_ctrl

`default_nettype wire

// ==== design/pmc_debounce.sv ====
/*
  key debounce on the 32 kHz tick enable.
  assumes level is already synchronised to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module pmc_debounce
  import pmc_pkg::*;
#(
  parameter logic [7:0] TICKS = DEB_TICKS
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic tick,
  input  wire logic level,
  output logic      valid,
  output logic      invalid
);

  logic       busy_q;
  logic [7:0] cnt_q;

  // ****************************************************************
  // counter
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q  <= 1'b0;
      cnt_q   <= 8'h00;
      valid   <= 1'b0;
      invalid <= 1'b0;
    end else begin
      valid   <= 1'b0;
      invalid <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        cnt_q  <= TICKS;
      end else if (busy_q && tick) begin
        if (!level) begin
          busy_q  <= 1'b0;
          invalid <= 1'b1;
        end else if (cnt_q <= 8'h01) begin
          busy_q <= 1'b0;
          valid  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end

endmodule // pmc_debounce

`default_nettype wire

// ==== design/pmc_pkg.sv ====
/*
  constants, types and register layout of the power mode clock controller.
  assumes a single 25 MHz system clock and an i2c slave engine on that
  clock that presents decoded register accesses.
*/

`default_nettype none

package pmc_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ    = 25_000_000;
  localparam int unsigned SLOW_HZ   = 32_768;
  localparam int unsigned SLOW_DIV  = (CLK_HZ + SLOW_HZ / 2) / SLOW_HZ;
  localparam int unsigned MS_PER_S  = 1000;
  localparam logic [7:0]  DEB_TICKS = 8'h20;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_SYSCTL  = 8'h02;
  localparam logic [7:0] ADDR_SYSCTL2 = 8'h03;
  localparam logic [7:0] SYSCTL_RST   = 8'h0f;
  localparam logic [7:0] SYSCTL2_RST  = 8'h00;
  localparam int unsigned BIT_SLEEP   = 4;
  localparam int unsigned BIT_OSCOFF  = 5;
  localparam int unsigned BIT_EXTCLK  = 6;
  localparam int unsigned BIT_SRST    = 7;
  localparam int unsigned BIT_DOZE_EN = 3;
  localparam logic        RW_WRITE    = 1'b0;

  localparam int unsigned DOZE_MS [8] =
    '{4, 16, 32, 64, 128, 256, 512, 1024};

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PMC_OPER,
    PMC_SLEEP,
    PMC_HIBER,
    PMC_KEYCHK
  } pmc_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmc_reg_req_t;

  typedef struct packed {
    logic [3:0] rc_en;
    logic [3:0] slow_en;
  } pmc_gate_t;

  function automatic logic [15:0] doze_ticks(input logic [2:0] sel);
    doze_ticks = 16'(DOZE_MS[sel] * SLOW_HZ / MS_PER_S);
  endfunction

endpackage

`default_nettype wire

// ==== dv/pmc_host_model.sv ====
/*
  host side of pmc_ctrl: the serial clock of one frame and the decoded
  address and stop events of the i2c slave engine.
  assumes clk is the device clock; the serial clock line has a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none

module pmc_host_model (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic dir,
  input  wire logic scl_oe_n,
  output logic      scl_i,
  output logic      addr_match,
  output logic      rw_bit,
  output logic      txn_done,
  output logic      done
);
  logic drv_low;
  int   n;

  // ****************************************************************
  // serial clock wire, low while either side pulls
  // ****************************************************************
  assign scl_i = (drv_low || !scl_oe_n) ? 1'b0 : 1'b1;

  initial begin
    drv_low    = 1'b0;
    addr_match = 1'b0;
    rw_bit     = 1'b1;
    txn_done   = 1'b0;
    done       = 1'b0;
  end

  task automatic bits(input int k);
    for (int i = 0; i < k; i++) begin
      drv_low = 1'b1;
      #160;
      drv_low = 1'b0;
      #160;
    end
  endtask

  // ****************************************************************
  // one frame: address byte, register byte, stop
  // ****************************************************************
  always @(posedge go) begin
    done = 1'b0;
    bits(8); // address then direction
    drv_low = 1'b1;
    @(posedge clk);
    addr_match <= 1'b1;
    rw_bit     <= dir; // one read, zero write
    @(posedge clk);
    addr_match <= 1'b0;
    rw_bit     <= ~dir;
    #160;
    drv_low = 1'b0;
    n = 0;
    while (scl_i == 1'b0 && n < 400) begin // waits out stretch
      @(posedge clk);
      n++;
    end
    #160;
    bits(9); // register address byte
    @(posedge clk);
    txn_done <= 1'b1;
    @(posedge clk);
    txn_done <= 1'b0;
    done = 1'b1;
  end
endmodule // pmc_host_model

`default_nettype wire

// ==== dv/test_pmc_ctrl.sv ====
/*
  self-checking bench of pmc_ctrl through its register port.
  assumes pmc_pkg and pmc_host_model; fast oscillator modelled as a delay.
*/
`timescale 1ns/1ps
`default_nettype none

module test_pmc_ctrl;
  import pmc_pkg::*;
  localparam int unsigned TD = 2;
  logic         clk, rst, go, dir, done, saw_str, saw_srst;
  pmc_reg_req_t req;
  logic [7:0]   rd_data, rc_pipe, v;
  logic         addr_match, rw_bit, txn_done, scl_i, scl_o, scl_oe_n;
  logic         rc_ready, wake_pin, key_detect, hotkey_evt, key_scan_irq;
  logic         rotary_irq, rc_osc_on, osc_off, ext_clk_sel, soft_reset;
  pmc_gate_t    gate;
  pmc_state_t   mode;
  int           fails, checked, cyc, n, e;

  pmc_ctrl #(.TICK_DIV(TD)) dut_u (.clk(clk), .rst(rst), .reg_req(req),
    .rd_data(rd_data), .addr_match(addr_match), .rw_bit(rw_bit),
    .txn_done(txn_done), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .rc_ready(rc_ready), .wake_pin(wake_pin),
    .key_detect(key_detect), .hotkey_evt(hotkey_evt),
    .key_scan_irq(key_scan_irq), .rotary_irq(rotary_irq), .gate(gate),
    .rc_osc_on(rc_osc_on), .osc_off(osc_off), .ext_clk_sel(ext_clk_sel),
    .soft_reset(soft_reset), .mode(mode));

  pmc_host_model host_u (.clk(clk), .go(go), .dir(dir),
    .scl_oe_n(scl_oe_n), .scl_i(scl_i), .addr_match(addr_match),
    .rw_bit(rw_bit), .txn_done(txn_done), .done(done));

  // ****************************************************************
  // clock, oscillator delay, monitors
  // ****************************************************************
  always #20 clk = ~clk;
  assign rc_ready = rc_pipe[7];
  always @(posedge clk) begin
    rc_pipe <= {rc_pipe[6:0], rc_osc_on};
    cyc++;
    if (!scl_oe_n) saw_str <= 1'b1;
    if (soft_reset) saw_srst <= 1'b1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    step(3);
  endtask

  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req.rd <= 1'b0;
    step(1);
    chk("rd_data", rd_data, exp);
  endtask

  task automatic host(input logic d);
    int k;
    @(posedge clk);
    go  <= 1'b1;
    dir <= d;
    k = 0;
    step(1);
    while (!done && k < 2000) begin
      step(1);
      k++;
    end
    go <= 1'b0;
    chk("host", 8'(done), 8'h01);
  endtask

  task automatic wait_mode(input pmc_state_t m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      step(1);
      n++;
    end
    chk("mode", 8'(mode), 8'(m));
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    clk = 0; rst = 1; go = 0; dir = 0; rc_pipe = 0; req = '0;
    {wake_pin, hotkey_evt, key_scan_irq, rotary_irq, key_detect} = '0;
    fails = 0; checked = 0; cyc = 0; saw_str = 0; saw_srst = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    step(3);
    rd(ADDR_SYSCTL, SYSCTL_RST);
    rd(ADDR_SYSCTL2, SYSCTL2_RST);
    rd(8'h01, 8'h00);
    chk("gate", gate, 8'hff);
    chk("rc_osc_on", 8'(rc_osc_on), 8'h01);
    chk("ext_clk_sel", 8'(ext_clk_sel), 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'h0f ^ (8'h01 << i);
      wr(ADDR_SYSCTL, v);
      chk("gate", gate, {v[3:0], v[3:0]});
    end
    wr(ADDR_SYSCTL, 8'h4f);
    chk("ext_clk_sel", 8'(ext_clk_sel), 8'h01);
    rd(ADDR_SYSCTL, 8'h4f);
    wr(ADDR_SYSCTL2, 8'hff);
    rd(ADDR_SYSCTL2, 8'h0f);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_SYSCTL2, 8'(c));
      rd(ADDR_SYSCTL2, 8'(c));
    end
    // sleep, writes refused, read-direction match refused
    wr(ADDR_SYSCTL, 8'h1a);
    chk("mode", 8'(mode), 8'(PMC_SLEEP));
    chk("gate", gate, 8'h0a);
    chk("rc_osc_on", 8'(rc_osc_on), 8'h00);
    wr(ADDR_SYSCTL, 8'h0f);
    chk("gate", gate, 8'h0a);
    host(1'b1);
    chk("mode", 8'(mode), 8'(PMC_SLEEP));
    saw_str <= 1'b0;
    host(1'b0);
    chk("mode", 8'(mode), 8'(PMC_OPER));
    chk("stretch", 8'(saw_str), 8'h01);
    chk("scl_oe_n", 8'(scl_oe_n), 8'h01);
    chk("scl_o", 8'(scl_o), 8'h00);
    chk("gate", gate, 8'haa);
    // pin and interrupt wake sources
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_SYSCTL, 8'h1f);
      chk("mode", 8'(mode), 8'(PMC_SLEEP));
      @(posedge clk);
      {wake_pin, hotkey_evt, key_scan_irq, rotary_irq} <= 4'h8 >> k;
      step(4);
      @(posedge clk);
      {wake_pin, hotkey_evt, key_scan_irq, rotary_irq} <= 4'h0;
      wait_mode(PMC_OPER, 20);
    end
    // hibernate, hotkey ignored, short and valid keypress
    wr(ADDR_SYSCTL, 8'h2f);
    chk("mode", 8'(mode), 8'(PMC_HIBER));
    chk("osc_off", 8'(osc_off), 8'h01);
    chk("gate", gate, 8'h00);
    chk("rc_osc_on", 8'(rc_osc_on), 8'h00);
    @(posedge clk);
    hotkey_evt <= 1'b1;
    step(4);
    @(posedge clk);
    hotkey_evt <= 1'b0;
    step(10);
    chk("mode", 8'(mode), 8'(PMC_HIBER));
    @(posedge clk);
    key_detect <= 1'b1;
    wait_mode(PMC_KEYCHK, 10);
    @(posedge clk);
    key_detect <= 1'b0;
    wait_mode(PMC_HIBER, 40 * TD);
    @(posedge clk);
    key_detect <= 1'b1;
    wait_mode(PMC_SLEEP, 40 * TD + 20);
    @(posedge clk);
    key_detect <= 1'b0;
    step(10);
    chk("mode", 8'(mode), 8'(PMC_SLEEP));
    host(1'b0);
    chk("mode", 8'(mode), 8'(PMC_OPER));
    chk("osc_off", 8'(osc_off), 8'h00);
    rd(ADDR_SYSCTL, 8'h0f);
    // hibernate left straight by i2c wake, then by a hard reset
    wr(ADDR_SYSCTL, 8'h2f);
    chk("mode", 8'(mode), 8'(PMC_HIBER));
    host(1'b0);
    chk("mode", 8'(mode), 8'(PMC_OPER));
    chk("osc_off", 8'(osc_off), 8'h00);
    wr(ADDR_SYSCTL, 8'h6f);
    chk("mode", 8'(mode), 8'(PMC_HIBER));
    chk("ext_clk_sel", 8'(ext_clk_sel), 8'h01);
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    step(2);
    chk("mode", 8'(mode), 8'(PMC_OPER));
    chk("ext_clk_sel", 8'(ext_clk_sel), 8'h00);
    rd(ADDR_SYSCTL, SYSCTL_RST);
    // auto-sleep timing from the last own transaction
    for (int c = 0; c < 2; c++) begin
      wr(ADDR_SYSCTL2, 8'h08 | 8'(c));
      host(1'b0);
      e = DOZE_MS[c] * SLOW_HZ / MS_PER_S * TD;
      wait_mode(PMC_SLEEP, e + 20);
      chk("doze", 8'(n >= e - 3 * TD - 4), 8'h01);
      host(1'b0);
    end
    wr(ADDR_SYSCTL2, 8'h00);
    step(300);
    chk("mode", 8'(mode), 8'(PMC_OPER));
    // soft reset restores both registers, the gates and the clock select
    wr(ADDR_SYSCTL, 8'h40);
    wr(ADDR_SYSCTL2, 8'h0d);
    saw_srst <= 1'b0;
    wr(ADDR_SYSCTL, 8'hc0);
    step(6);
    chk("soft_reset", 8'(saw_srst), 8'h01);
    rd(ADDR_SYSCTL, SYSCTL_RST);
    rd(ADDR_SYSCTL2, SYSCTL2_RST);
    chk("gate", gate, 8'hff);
    chk("ext_clk_sel", 8'(ext_clk_sel), 8'h00);
    end_sim();
  end
endmodule // test_pmc_ctrl

`default_nettype wire
